// [core/aacr_regs.sv]
// Control registers 3, 4, 6 and 7 with mute ramp and page address stepping
module aacr_regs
   import aacr_pkg::*;
(
   input  wire logic       core_clk,         // Core clock, 250 MHz
   input  wire logic       rst_n,            // Synchronous reset, active low
   input  wire logic [7:0] reg_addr,         // Register offset from the control port
   input  wire logic       reg_wr,           // Write strobe, one cycle
   input  wire logic [7:0] reg_wdata,        // Write data
   output logic      [7:0] reg_rdata,        // Read data for reg_addr
   input  wire logic       pll_locked,       // Lock level from the PLL
   input  wire logic       book_nonzero,     // Current book is not zero
   input  wire logic       addr_step,        // Auto-increment step request, one cycle
   input  wire logic [7:0] page_in,          // Current page
   input  wire logic [6:0] loc_in,           // Current location within page
   output logic      [7:0] next_page,        // Page after the step
   output logic      [6:0] next_loc,         // Location after the step
   output logic            left_mute_request,  // Left mute request level
   output logic            right_mute_request, // Right mute request level
   output logic      [7:0] left_gain,        // Left ramped gain
   output logic      [7:0] right_gain,       // Right ramped gain
   output logic            pll_enable_bit,   // PLL enable to the PLL
   output logic            mclk_from_pin,    // Master clock mux selects the pin
   output logic            deemphasis_enable, // De-emphasis in path
   output logic            serial_out_source_select // 1 pre-, 0 post-processing
);
   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic       page_increment_disable; // Page wrap mode
   logic [7:0] ramp_cnt;               // Ramp step divider
   logic       ramp_tick;              // One ramp step this cycle

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   wire wr_mute = reg_wr && (reg_addr == AACR_OFS_MUTE); // Register 3 write
   wire wr_pll  = reg_wr && (reg_addr == AACR_OFS_PLL);  // Register 4 write
   wire wr_page = reg_wr && (reg_addr == AACR_OFS_PAGE); // Register 6 write
   wire wr_filt = reg_wr && (reg_addr == AACR_OFS_FILT); // Register 7 write
   wire pll_lock_flag = !pll_enable_bit || !pll_locked;  // RL4 RL5
   assign ramp_tick = (ramp_cnt == AACR_RAMP_DIV);
   assign mclk_from_pin = !pll_enable_bit; // RL7

   // Step one gain toward its target by one unit
   function automatic logic [7:0] ramp_step(input logic [7:0] g, input logic mute);
      if (mute && g != AACR_VOL_MIN) return 8'(g - 8'h01);
      if (!mute && g != AACR_VOL_MAX) return 8'(g + 8'h01);
      return g;
   endfunction

   // -----------------------------------------------------------------
   // Read mux, reserved bits zero
   // -----------------------------------------------------------------
   // Only mapped fields are placed; every other bit stays at zero
   // Reads have no side effect, so the host may poll freely
   always_comb begin
      reg_rdata = 8'h00; // RL13
      unique case (reg_addr)
         AACR_OFS_MUTE: begin
            reg_rdata[AACR_BIT_MUTE_L] = left_mute_request;
            reg_rdata[AACR_BIT_MUTE_R] = right_mute_request;
         end
         AACR_OFS_PLL: begin
            reg_rdata[AACR_BIT_LOCK]   = pll_lock_flag; // RL4
            reg_rdata[AACR_BIT_PLL_EN] = pll_enable_bit;
         end
         AACR_OFS_PAGE: reg_rdata[AACR_BIT_PG_DIS] = page_increment_disable;
         AACR_OFS_FILT: begin
            reg_rdata[AACR_BIT_DEEMPH] = deemphasis_enable;
            reg_rdata[AACR_BIT_SOURCE] = serial_out_source_select;
         end
         default: reg_rdata = 8'h00; // Unmapped reads zero
      endcase
   end

   // -----------------------------------------------------------------
   // Register writes, only defined bits stored
   // -----------------------------------------------------------------
   // Reset values first, then one write enable per register
   // Bits outside the mapped fields are never stored
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         left_mute_request        <= AACR_RST_MUTE;
         right_mute_request       <= AACR_RST_MUTE;
         pll_enable_bit           <= AACR_RST_PLL_EN; // RL6
         page_increment_disable   <= AACR_RST_PG_DIS;
         deemphasis_enable        <= AACR_RST_DEEMPH;
         serial_out_source_select <= AACR_RST_SOURCE;
      end else begin
         if (wr_mute) begin
            left_mute_request  <= reg_wdata[AACR_BIT_MUTE_L]; // RL1
            right_mute_request <= reg_wdata[AACR_BIT_MUTE_R]; // RL2
         end
         if (wr_pll) pll_enable_bit <= reg_wdata[AACR_BIT_PLL_EN]; // RL6
         if (wr_page) page_increment_disable <= reg_wdata[AACR_BIT_PG_DIS];
         if (wr_filt) begin
            deemphasis_enable        <= reg_wdata[AACR_BIT_DEEMPH]; // RL10 RL11
            serial_out_source_select <= reg_wdata[AACR_BIT_SOURCE]; // RL12
         end
      end
   end

   // -----------------------------------------------------------------
   // Soft mute ramp, one gain step per divider period
   // -----------------------------------------------------------------
   // Free-running divider; gains move only on its terminal count
   // A mute change mid-ramp simply reverses the direction of travel
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ramp_cnt   <= 8'h00;
         left_gain  <= AACR_VOL_MAX;
         right_gain <= AACR_VOL_MAX;
      end else begin
         ramp_cnt <= ramp_tick ? 8'h00 : 8'(ramp_cnt + 8'h01);
         if (ramp_tick) begin
            left_gain  <= ramp_step(left_gain, left_mute_request);   // RL3
            right_gain <= ramp_step(right_gain, right_mute_request); // RL3
         end
      end
   end

   // -----------------------------------------------------------------
   // Auto-increment address stepping
   // -----------------------------------------------------------------
   wire at_end = addr_step && (loc_in == AACR_PAGE_END); // Page end reached
   wire wrap   = !book_nonzero || page_increment_disable; // RL9
   // Plain step inside a page, special cases only at the page end
   // Book zero always wraps inside the page
   always_comb begin
      next_page = page_in;
      next_loc  = addr_step ? 7'(loc_in + 7'h01) : loc_in;
      if (at_end && wrap) begin
         next_loc = AACR_PAGE_WRAP; // RL9
      end else if (at_end) begin
         next_page = 8'(page_in + 8'h01); // RL8
         next_loc  = AACR_PAGE_RESTART;   // RL8
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // Lock flag forced to not locked while the PLL is off
   a_lock_when_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
      (!pll_enable_bit && reg_addr == AACR_OFS_PLL) |-> reg_rdata[AACR_BIT_LOCK])
      else $error("lock flag shows locked while PLL off");

   // Lock flag reads zero when enabled and locked
   a_lock_polarity: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
      (pll_enable_bit && pll_locked && reg_addr == AACR_OFS_PLL)
      |-> !reg_rdata[AACR_BIT_LOCK])
      else $error("lock flag wrong when locked");

   // Lock flag reads one when enabled but not locked
   a_lock_unlocked: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
      (pll_enable_bit && !pll_locked && reg_addr == AACR_OFS_PLL)
      |-> reg_rdata[AACR_BIT_LOCK])
      else $error("lock flag wrong when unlocked");

   // Clock mux moves to the pin once the PLL is turned off
   a_clock_mux_pin: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
      (wr_pll && !reg_wdata[AACR_BIT_PLL_EN]) |=> mclk_from_pin)
      else $error("clock mux not on pin after PLL off");

   // Clock mux returns to the PLL once it is turned on
   a_clock_mux_pll: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
      (wr_pll && reg_wdata[AACR_BIT_PLL_EN]) |=> !mclk_from_pin)
      else $error("clock mux on pin while PLL on");

   // PLL enable takes the written bit
   a_pll_en_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
      wr_pll |=> pll_enable_bit == $past(reg_wdata[AACR_BIT_PLL_EN]))
      else $error("PLL enable not stored");

   // Left request takes the written bit
   a_left_mute_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
      wr_mute |=> left_mute_request == $past(reg_wdata[AACR_BIT_MUTE_L]))
      else $error("left mute not stored");

   // Right request takes the written bit
   a_right_mute_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
      wr_mute |=> right_mute_request == $past(reg_wdata[AACR_BIT_MUTE_R]))
      else $error("right mute not stored");

   // Requests change only on a write to their register
   a_mute_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1 RL2
      !wr_mute |=> ($stable(left_mute_request) && $stable(right_mute_request)))
      else $error("mute request changed without a write");

   // Left gain moves by one unit at most, reset edges excluded
   a_gain_no_step: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
      ($past(rst_n) && left_gain != $past(left_gain))
      |-> (left_gain - $past(left_gain) == 8'h01 || $past(left_gain) - left_gain == 8'h01))
      else $error("left gain jumped");

   // Right gain moves by one unit at most, reset edges excluded
   a_right_no_step: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
      ($past(rst_n) && right_gain != $past(right_gain))
      |-> (right_gain - $past(right_gain) == 8'h01 || $past(right_gain) - right_gain == 8'h01))
      else $error("right gain jumped");

   // Page end in a non-zero book with the disable bit clear continues on the next page
   a_page_advance: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
      (at_end && book_nonzero && !page_increment_disable)
      |-> (next_loc == AACR_PAGE_RESTART && next_page == 8'(page_in + 8'h01)))
      else $error("page end did not advance to location 8");

   // Page end with the disable bit set stays on the page
   a_page_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
      (at_end && page_increment_disable)
      |-> (next_loc == AACR_PAGE_WRAP && next_page == page_in))
      else $error("page end did not wrap");

   // Page disable takes the written bit
   a_page_bit_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
      wr_page |=> page_increment_disable == $past(reg_wdata[AACR_BIT_PG_DIS]))
      else $error("page disable not stored");

   // Filter and source fields take the written bits
   a_filter_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10 RL12
      wr_filt |=> (deemphasis_enable == $past(reg_wdata[AACR_BIT_DEEMPH])
      && serial_out_source_select == $past(reg_wdata[AACR_BIT_SOURCE])))
      else $error("register 7 fields not stored");

   // Reserved bits of the mute register read zero
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
      (reg_addr == AACR_OFS_MUTE) |-> (reg_rdata & 8'hee) == 8'h00)
      else $error("reserved bits read nonzero");

   // Reserved bits of the PLL and filter registers read zero
   a_reserved_rest: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
      (reg_addr == AACR_OFS_PLL || reg_addr == AACR_OFS_FILT)
      |-> (reg_rdata & 8'hee) == 8'h00)
      else $error("reserved bits of registers 4 or 7 read nonzero");

   // Reserved bits of the page register read zero
   a_reserved_page: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
      (reg_addr == AACR_OFS_PAGE) |-> (reg_rdata & 8'hf7) == 8'h00)
      else $error("reserved bits of register 6 read nonzero");

   // Offsets outside the slice read zero
   a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
      (reg_addr != AACR_OFS_MUTE && reg_addr != AACR_OFS_PLL
      && reg_addr != AACR_OFS_PAGE && reg_addr != AACR_OFS_FILT)
      |-> reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");
endmodule // aacr_regs

// [core/aacr_pkg.sv]
// Constants for the amplifier control register slice, registers 3 to 7
//
// Summary of operation
// RL1: Register 3 bit 4 requests left soft mute
// RL2: Register 3 bit 0 requests right soft mute
// RL3: Mute changes ramp volume gradually, never step
// RL4: Register 4 bit 4 reads 1 when unlocked
// RL5: Disabled PLL always reads as not locked
// RL6: Register 4 bit 0 enables PLL, resets 1
// RL7: Disabled PLL selects external master clock pin
// RL8: Bit clear: page end continues at location 8 of next page; in book zero the code wraps to location 0 instead
// RL9: Bit set: page end wraps to location 0
// RL10: Register 7 bit 4 enables de-emphasis filter
// RL11: De-emphasis defaults suit 44.1 kHz, rewritable
// RL12: Register 7 bit 0 picks serial output source
// RL13: Reserved bits ignore writes, read zero
package aacr_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] AACR_OFS_MUTE  = 8'h03; // Channel mute request
   localparam logic [7:0] AACR_OFS_PLL   = 8'h04; // PLL control and status
   localparam logic [7:0] AACR_OFS_PAGE  = 8'h06; // Page increment control
   localparam logic [7:0] AACR_OFS_FILT  = 8'h07; // Filter and output select
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int AACR_BIT_MUTE_L  = 4; // Left mute request
   localparam int AACR_BIT_MUTE_R  = 0; // Right mute request
   localparam int AACR_BIT_LOCK    = 4; // PLL lock flag
   localparam int AACR_BIT_PLL_EN  = 0; // PLL enable
   localparam int AACR_BIT_PG_DIS  = 3; // Page increment disable
   localparam int AACR_BIT_DEEMPH  = 4; // De-emphasis enable
   localparam int AACR_BIT_SOURCE  = 0; // Serial out source select
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic AACR_RST_MUTE   = 1'b0; // Mutes off
   localparam logic AACR_RST_PLL_EN = 1'b1; // PLL enabled
   localparam logic AACR_RST_PG_DIS = 1'b0; // Page increment on
   localparam logic AACR_RST_DEEMPH = 1'b0; // Filter bypassed
   localparam logic AACR_RST_SOURCE = 1'b1; // Pre-processing source
   // -----------------------------------------------------------------
   // Page addressing and volume ramp
   // -----------------------------------------------------------------
   localparam logic [6:0] AACR_PAGE_END     = 7'h7f; // Last location of page
   localparam logic [6:0] AACR_PAGE_RESTART = 7'h08; // Next page restart location
   localparam logic [6:0] AACR_PAGE_WRAP    = 7'h00; // Same page wrap location
   localparam logic [7:0] AACR_VOL_MAX      = 8'hff; // Full gain
   localparam logic [7:0] AACR_VOL_MIN      = 8'h00; // Muted gain
   localparam logic [7:0] AACR_RAMP_DIV     = 8'h3f; // Divider terminal count, ramp steps 64 cycles apart
endpackage : aacr_pkg

// [verif/aacr_host.sv]
// Host model that issues register writes and reads on the control port
module aacr_host
   import aacr_pkg::*;
(
   input  wire logic       core_clk,  // Core clock
   output logic      [7:0] reg_addr,  // Register offset
   output logic            reg_wr,    // Write strobe
   output logic      [7:0] reg_wdata, // Write data
   input  wire logic [7:0] reg_rdata  // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Idle levels and access tasks
   // ---------------------------------------------
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end
   // One-cycle strobe, address and data held across the taking edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d; // Released data must not look valid
   endtask
   // Combinational read, sampled once settled
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      #1;
      d = reg_rdata;
   endtask
endmodule // aacr_host

// [verif/test_audio_amp_control_regs_3_to_7.sv]
// Self-checking bench for the register slice against a behavioural register model
module test_audio_amp_control_regs_3_to_7;
   import aacr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk, rst_n, reg_wr, pll_locked, book_nonzero, addr_step;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, page_in, next_page, left_gain, right_gain, rd;
   logic [6:0] loc_in, next_loc;
   logic       mute_l, mute_r, pll_en, mclk_pin, deemph, source;
   int         n_errors = 0, n_tests = 0, seed = 32'hdae712c5, i, p;
   logic [7:0] ofs[5] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h05}; // Last one unmapped
   logic [7:0] msk[5] = '{8'h11, 8'h01, 8'h08, 8'h11, 8'h00}; // Writable bits
   logic [7:0] img[5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00}; // Model image at reset
   // ---------------------------------------------
   // Clock, design and host
   // ---------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   aacr_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_locked(pll_locked),
      .book_nonzero(book_nonzero), .addr_step(addr_step), .page_in(page_in), .loc_in(loc_in),
      .next_page(next_page), .next_loc(next_loc), .left_mute_request(mute_l),
      .right_mute_request(mute_r), .left_gain(left_gain), .right_gain(right_gain),
      .pll_enable_bit(pll_en), .mclk_from_pin(mclk_pin), .deemphasis_enable(deemph),
      .serial_out_source_select(source));
   aacr_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // ---------------------------------------------
   // Compare, model and closing tasks
   // ---------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Write through the host and keep only writable bits in the model
   task automatic wr(input int j, input logic [7:0] d);
      host_u.write_reg(ofs[j], d);
      img[j] = d & msk[j];
   endtask
   // Read every offset and compare outputs with the model
   task automatic check_all;
      for (int j = 0; j < 5; j++) begin
         host_u.read_reg(ofs[j], rd);
         chk(rd, img[j] | ((j == 1 && (!img[1][0] || !pll_locked)) ? 8'h10 : 8'h00));
      end
      chk({2'b00, mute_l, mute_r, pll_en, mclk_pin, deemph, source}, {2'b00, img[0][4], img[0][0],
          img[1][0], !img[1][0], img[3][4], img[3][0]});
   endtask
   // Follow both gains to their targets, one unit per step
   task automatic ramp(input logic [7:0] tl, input logic [7:0] tr);
      logic [7:0] pl;
      logic [7:0] pr;
      int         k;
      pl = left_gain;
      pr = right_gain;
      for (k = 0; k < 17000 && (left_gain !== tl || right_gain !== tr); k++) begin
         @(negedge core_clk);
         if (left_gain !== pl) chk(left_gain, tl == 8'hff ? 8'(pl + 8'h01) : 8'(pl - 8'h01));
         if (right_gain !== pr) chk(right_gain, tr == 8'hff ? 8'(pr + 8'h01) : 8'(pr - 8'h01));
         pl = left_gain;
         pr = right_gain;
      end
      chk(left_gain, tl);
      chk(right_gain, tr);
      if (k >= 17000) begin
         n_errors++;
         $display("MISMATCH at %0t: gain ramp timed out", $time);
         end_of_test();
      end
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      pll_locked = 1'b1;
      book_nonzero = 1'b0;
      addr_step = 1'b0;
      page_in = 8'h00;
      loc_in = 7'h00;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      check_all();
      chk(left_gain, 8'hff);
      // Random writes, unmapped offset and lock level included
      for (i = 0; i < 30; i++) begin
         pll_locked = 1'($random(seed));
         wr(($random(seed) & 32'h7fff) % 5, 8'($random(seed)));
         check_all();
      end
      // Mid-run reset brings every field back to its reset value
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      img = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
      check_all();
      chk(left_gain, 8'hff);
      chk(right_gain, 8'hff);
      // Address stepping with the page disable bit clear then set
      for (p = 0; p < 2; p++) begin
         wr(2, 8'($random(seed)) & 8'hf7 | (p ? 8'h08 : 8'h00));
         for (i = 0; i < 24; i++) begin
            @(negedge core_clk);
            page_in = 8'($random(seed));
            loc_in = (i % 2) ? 7'h7f : 7'($random(seed));
            book_nonzero = 1'($random(seed));
            addr_step = 1'b1;
            #1;
            chk(next_page, page_in + ((loc_in == 7'h7f && book_nonzero && !img[2][3]) ? 8'h01 : 8'h00));
            chk({1'b0, next_loc}, loc_in != 7'h7f ? {1'b0, loc_in + 7'h01} :
                (book_nonzero && !img[2][3]) ? 8'h08 : 8'h00);
         end
      end
      addr_step = 1'b0;
      // Soft mute left down, swap to right, then both back up
      wr(0, 8'h10);
      ramp(8'h00, 8'hff);
      wr(0, 8'h01);
      ramp(8'hff, 8'h00);
      wr(0, 8'h00);
      ramp(8'hff, 8'hff);
      end_of_test();
   end
endmodule // test_audio_amp_control_regs_3_to_7
